// File: hw/tsc_pkg.sv
package tsc_pkg;

	localparam int ADDR_W = 5;

	// register byte offsets
	localparam logic [4:0] OFS_OPCFG = 5'h00;
	localparam logic [4:0] OFS_NVCFG = 5'h04;
	localparam logic [4:0] OFS_CMD   = 5'h08;
	localparam logic [4:0] OFS_STAT  = 5'h0C;

	// field positions
	localparam int BIT_BUSY    = 0;
	localparam int BIT_LOCK    = 1;
	localparam int BIT_LOCKDN  = 2;
	localparam int CFG_LSB     = 8;
	localparam int CFG_MSB     = 14;
	localparam int CMD_TO_NV   = 0;
	localparam int CMD_FROM_NV = 1;

	localparam logic [15:0] NV_WMASK    = 16'h7F06;
	localparam logic [15:0] NV_FACTORY  = 16'h0000;
	localparam logic [15:0] LOCK_MASK   = 16'h0002;
	localparam logic [15:0] LOCKDN_MASK = 16'h0004;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// self-timed nonvolatile programming
	localparam int unsigned PROG_TIME_MS  = 20;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned PROG_CYCLES   = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;

	// consecutive faults needed per queue code
	localparam logic [2:0] FQ_NEED0  = 3'h1;
	localparam logic [2:0] FQ_NEED1  = 3'h2;
	localparam logic [2:0] FQ_NEED2  = 3'h4;
	localparam logic [2:0] FQ_NEED3  = 3'h6;
	localparam logic [2:0] FAULT_MAX = 3'h6;

	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_RUN  = 2'b01,
		ST_SHDN = 2'b10
	} tsc_mode_t;

	// same order as bits 14:8 of the stored default word
	typedef struct packed {
		logic [1:0] resolution;
		logic [1:0] fault_queue_sel;
		logic       alarm_polarity;
		logic       thermostat_mode_sel;
		logic       shutdown_ctl;
	} tsc_cfg_t;

	typedef struct packed {
		logic                aw_full;
		logic [ADDR_W-1:0]   aw_addr;
		logic                w_full;
		logic [31:0]         w_data;
		logic [3:0]          w_strb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		tsc_cfg_t            cfg;
		logic                busy;
		logic [31:0]         prog_cnt;
		logic [15:0]         prog_data;
		tsc_mode_t           mode;
		logic [2:0]          sync_conv;
		logic [1:0]          sync_over;
		logic [2:0]          fault_cnt;
		logic                alarm;
		logic                alert;
		logic                conv_store;
	} tsc_state_t;

	typedef struct packed {
		logic [15:0] word;
	} tsc_nv_t;

	function automatic logic [2:0] fault_need(input logic [1:0] code);
		logic [2:0] n;
		unique case (code)
			2'b00: n = FQ_NEED0;
			2'b01: n = FQ_NEED1;
			2'b10: n = FQ_NEED2;
			2'b11: n = FQ_NEED3;
		endcase
		return n;
	endfunction : fault_need

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [15:0] r;
		r = old;
		if (st[0]) begin
			r[7:0] = wd[7:0];
		end
		if (st[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : merge16

endpackage : tsc_pkg

// File: hw/tsc_config_regs.sv
// Contract
// - fault queue codes need 1,2,4,6 faults
// - reset loads fault queue from stored default
// - alarm pin low-active if polarity 0
// - reset loads polarity from stored default
// - mode bit selects comparator or interrupt
// - reset loads thermostat mode from default
// - shutdown 0 means continuous conversions
// - shutdown finishes and stores current conversion
// - clearing shutdown resumes conversions
// - reset loads shutdown from stored default
// - busy flag shows nonvolatile access state
// - nonvolatile reads while busy are invalid
// - nonvolatile writes while busy are dropped
// - copy commands ignored while busy
// - sixteen-bit stored word survives reset
// - reset copies stored upper byte
// - stored fault queue in bits 12:11
// - stored polarity in bit 10
// - stored shutdown in bit 8
// - lockdown bit freezes everything forever, but a copy-from-nonvolatile command still reloads the config
// - lock bit rejects register changes, but a copy-from-nonvolatile command still reloads the config
// - stored resolution in bits 14:13
// - programming is self-timed under busy
// - under lock only lock clear accepted, but a copy-from-nonvolatile command is still accepted
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module tsc_nv_cells (
	input  wire logic        clk,
	input  wire logic        nv_rst_n,
	input  wire logic        we,
	input  wire logic [15:0] wdata,
	output logic      [15:0] word
);
	tsc_pkg::tsc_nv_t s_q;
	tsc_pkg::tsc_nv_t s_d;

	// own reset only: models cells that keep their value over device resets
	always_comb begin
		s_d = s_q;
		if (we) begin
			s_d.word = (wdata & tsc_pkg::NV_WMASK) | (s_q.word & tsc_pkg::LOCKDN_MASK);
		end
	end

	always_ff @(posedge clk or negedge nv_rst_n) begin
		if (!nv_rst_n) begin
			s_q <= '{word: tsc_pkg::NV_FACTORY};
		end else begin
			s_q <= s_d;
		end
	end

	assign word = s_q.word;
endmodule : tsc_nv_cells

module tsc_config_regs #(
	parameter int unsigned PROG_CYCLES = tsc_pkg::PROG_CYCLES
) (
	input  wire logic                     CLK,
	input  wire logic                     RESETN,
	input  wire logic                     NV_RESETN,
	input  wire logic                     AWVALID,
	output logic                          AWREADY,
	input  wire logic [tsc_pkg::ADDR_W-1:0] AWADDR,
	input  wire logic                     WVALID,
	output logic                          WREADY,
	input  wire logic [31:0]              WDATA,
	input  wire logic [3:0]               WSTRB,
	output logic                          BVALID,
	input  wire logic                     BREADY,
	output logic      [1:0]               BRESP,
	input  wire logic                     ARVALID,
	output logic                          ARREADY,
	input  wire logic [tsc_pkg::ADDR_W-1:0] ARADDR,
	output logic                          RVALID,
	input  wire logic                     RREADY,
	output logic      [31:0]              RDATA,
	output logic      [1:0]               RRESP,
	input  wire logic                     CONV_CLK,
	input  wire logic                     TEMP_OVER,
	output logic                          CONV_RUN,
	output logic                          CONV_STORE,
	output logic      [1:0]               RESOLUTION,
	output logic                          ALERT
);
	tsc_pkg::tsc_state_t q;
	tsc_pkg::tsc_state_t d;
	logic [15:0]         nv_word;
	logic                nv_we;
	logic                aw_take;
	logic                w_take;
	logic                ar_take;
	logic                wr_go;
	logic                conv_edge;
	logic                over_lvl;
	logic                locked;
	logic [15:0]         opcfg_rd;
	logic [15:0]         merged_nv;
	logic [15:0]         merged_op;
	logic [2:0]          need;
	logic [2:0]          cnt_new;

	assign nv_we = q.busy && (q.prog_cnt == 32'h0);

	tsc_nv_cells u_nv (
		.clk      (CLK),
		.nv_rst_n (NV_RESETN),
		.we       (nv_we),
		.wdata    (q.prog_data),
		.word     (nv_word)
	);

	assign AWREADY = !q.aw_full && !q.bvalid;
	assign WREADY  = !q.w_full && !q.bvalid;
	assign ARREADY = !q.rvalid;
	assign aw_take = AWVALID && AWREADY;
	assign w_take  = WVALID && WREADY;
	assign ar_take = ARVALID && ARREADY;
	assign wr_go   = q.aw_full && q.w_full && !q.bvalid;
	// first stage feeds only the second; edge found between stages two and three
	assign conv_edge = q.sync_conv[1] && !q.sync_conv[2];
	assign over_lvl  = q.sync_over[1];
	assign locked    = nv_word[tsc_pkg::BIT_LOCK] || nv_word[tsc_pkg::BIT_LOCKDN];
	assign opcfg_rd  = {1'b0, q.cfg, 7'h00, q.busy};
	assign merged_nv = tsc_pkg::merge16(nv_word, q.w_data, q.w_strb);
	assign merged_op = tsc_pkg::merge16(opcfg_rd, q.w_data, q.w_strb);
	assign need      = tsc_pkg::fault_need(q.cfg.fault_queue_sel);
	assign cnt_new   = !over_lvl ? 3'h0 :
		(q.fault_cnt == tsc_pkg::FAULT_MAX) ? tsc_pkg::FAULT_MAX : q.fault_cnt + 3'h1;

	always_comb begin
		d = q;
		d.conv_store = 1'b0;
		d.sync_conv  = {q.sync_conv[1:0], CONV_CLK};
		d.sync_over  = {q.sync_over[0], TEMP_OVER};

		if (q.busy) begin
			d.prog_cnt = q.prog_cnt - 32'h1;
			if (q.prog_cnt == 32'h0) begin
				d.busy = 1'b0;
			end
		end

		if (aw_take) begin
			d.aw_full = 1'b1;
			d.aw_addr = AWADDR;
		end
		if (w_take) begin
			d.w_full = 1'b1;
			d.w_data = WDATA;
			d.w_strb = WSTRB;
		end
		if (BVALID && BREADY) begin
			d.bvalid = 1'b0;
		end
		if (wr_go) begin
			d.aw_full = 1'b0;
			d.w_full  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = tsc_pkg::RESP_OKAY;
			unique case (q.aw_addr)
				tsc_pkg::OFS_OPCFG: begin
					if (!locked) begin
						d.cfg = tsc_pkg::tsc_cfg_t'(merged_op[tsc_pkg::CFG_MSB:tsc_pkg::CFG_LSB]);
					end
				end
				tsc_pkg::OFS_NVCFG: begin
					// a write lost to busy or locks still answers OKAY
					if (!q.busy && !nv_word[tsc_pkg::BIT_LOCKDN]) begin
						if (!nv_word[tsc_pkg::BIT_LOCK]) begin
							d.busy      = 1'b1;
							d.prog_cnt  = 32'(PROG_CYCLES - 1);
							d.prog_data = merged_nv & tsc_pkg::NV_WMASK;
						end else if (!merged_nv[tsc_pkg::BIT_LOCK]) begin
							d.busy      = 1'b1;
							d.prog_cnt  = 32'(PROG_CYCLES - 1);
							d.prog_data = nv_word & ~tsc_pkg::LOCK_MASK;
						end
					end
				end
				tsc_pkg::OFS_CMD: begin
					if (!q.busy) begin
						if (q.w_data[tsc_pkg::CMD_TO_NV] && !locked) begin
							d.busy      = 1'b1;
							d.prog_cnt  = 32'(PROG_CYCLES - 1);
							d.prog_data = {1'b0, q.cfg, nv_word[7:0]};
						end else if (q.w_data[tsc_pkg::CMD_FROM_NV]) begin
							d.cfg = tsc_pkg::tsc_cfg_t'(nv_word[tsc_pkg::CFG_MSB:tsc_pkg::CFG_LSB]);
						end
					end
				end
				tsc_pkg::OFS_STAT: begin
				end
				default: begin
					d.bresp = tsc_pkg::RESP_SLVERR;
				end
			endcase
		end

		if (RVALID && RREADY) begin
			d.rvalid = 1'b0;
		end
		if (ar_take) begin
			d.rvalid = 1'b1;
			d.rresp  = tsc_pkg::RESP_OKAY;
			// any read acknowledges a latched interrupt-mode alarm
			if (q.cfg.thermostat_mode_sel) begin
				d.alarm = 1'b0;
			end
			unique case (ARADDR)
				tsc_pkg::OFS_OPCFG: d.rdata = {16'h0000, opcfg_rd};
				tsc_pkg::OFS_NVCFG: d.rdata = q.busy ? 32'h0 : {16'h0000, nv_word};
				tsc_pkg::OFS_CMD:   d.rdata = 32'h0;
				tsc_pkg::OFS_STAT:  d.rdata = {26'h0, q.mode, q.fault_cnt, q.alarm};
				default: begin
					d.rdata = 32'h0;
					d.rresp = tsc_pkg::RESP_SLVERR;
				end
			endcase
		end

		unique case (q.mode)
			tsc_pkg::ST_LOAD: begin
				d.cfg  = tsc_pkg::tsc_cfg_t'(nv_word[tsc_pkg::CFG_MSB:tsc_pkg::CFG_LSB]);
				d.mode = nv_word[tsc_pkg::CFG_LSB] ? tsc_pkg::ST_SHDN : tsc_pkg::ST_RUN;
			end
			tsc_pkg::ST_RUN: begin
				if (conv_edge) begin
					d.conv_store = 1'b1;
					d.fault_cnt  = cnt_new;
					if (!q.cfg.thermostat_mode_sel) begin
						d.alarm = (cnt_new >= need);
					end else if (cnt_new >= need && q.fault_cnt < need) begin
						d.alarm = 1'b1; // set wins over the read clear
					end
					if (q.cfg.shutdown_ctl) begin
						d.mode = tsc_pkg::ST_SHDN;
					end
				end
			end
			tsc_pkg::ST_SHDN: begin
				if (!q.cfg.shutdown_ctl) begin
					d.mode = tsc_pkg::ST_RUN;
				end
			end
			default: d.mode = tsc_pkg::ST_LOAD;
		endcase

		d.alert = d.cfg.alarm_polarity ? d.alarm : !d.alarm;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			q       <= '0;
			q.alert <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign BVALID     = q.bvalid;
	assign BRESP      = q.bresp;
	assign RVALID     = q.rvalid;
	assign RDATA      = q.rdata;
	assign RRESP      = q.rresp;
	assign CONV_RUN   = (q.mode == tsc_pkg::ST_RUN);
	assign CONV_STORE = q.conv_store;
	assign RESOLUTION = q.cfg.resolution;
	assign ALERT      = q.alert;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	fault_count_a: assert property (
		q.mode == tsc_pkg::ST_RUN && conv_edge && !q.cfg.thermostat_mode_sel
		|=> q.alarm == (q.fault_cnt >= $past(need)))
		else $error("comparator alarm does not match fault queue depth");
	load_default_a: assert property (
		q.mode == tsc_pkg::ST_LOAD |=> q.cfg == $past(nv_word[tsc_pkg::CFG_MSB:tsc_pkg::CFG_LSB]))
		else $error("reset did not copy stored upper byte");
	alert_level_a: assert property (
		ALERT == (q.cfg.alarm_polarity ? q.alarm : !q.alarm))
		else $error("alarm pin polarity wrong");
	int_hold_a: assert property (
		q.cfg.thermostat_mode_sel && q.alarm && !ar_take && !wr_go |=> q.alarm)
		else $error("interrupt alarm dropped without a read");
	run_cont_a: assert property (
		q.mode == tsc_pkg::ST_RUN && !q.cfg.shutdown_ctl |=> CONV_RUN)
		else $error("conversions stopped while shutdown is clear");
	sd_finish_a: assert property (
		q.mode == tsc_pkg::ST_RUN && q.cfg.shutdown_ctl && conv_edge
		|=> CONV_STORE && q.mode == tsc_pkg::ST_SHDN)
		else $error("shutdown entered without storing the conversion");
	sd_wait_a: assert property (
		q.mode == tsc_pkg::ST_RUN && !conv_edge |=> q.mode != tsc_pkg::ST_SHDN)
		else $error("shutdown cut a conversion short");
	wake_up_a: assert property (
		q.mode == tsc_pkg::ST_SHDN && !q.cfg.shutdown_ctl |=> q.mode == tsc_pkg::ST_RUN)
		else $error("shutdown not left after clear");
	busy_read_a: assert property (
		ar_take && ARADDR == tsc_pkg::OFS_OPCFG |=> RVALID && RDATA[tsc_pkg::BIT_BUSY] == $past(q.busy))
		else $error("busy flag not reported");
	busy_drop_a: assert property (
		q.busy && q.prog_cnt != 32'h0 && wr_go |=> q.busy && $stable(q.prog_data))
		else $error("write accepted while busy");
	copy_ignore_a: assert property (
		q.busy && wr_go && q.aw_addr == tsc_pkg::OFS_CMD |=> $stable(q.prog_data) && $stable(q.cfg))
		else $error("copy command acted while busy");
	prog_done_a: assert property (
		nv_we |=> !q.busy ##0 nv_word == ($past(q.prog_data) & tsc_pkg::NV_WMASK | $past(nv_word) & tsc_pkg::LOCKDN_MASK))
		else $error("programming did not land in the stored word");
	lockdown_keep_a: assert property (
		nv_word[tsc_pkg::BIT_LOCKDN] |=> nv_word[tsc_pkg::BIT_LOCKDN])
		else $error("lockdown bit cleared");
	lock_only_a: assert property (
		nv_word[tsc_pkg::BIT_LOCK] && !q.busy |=> !$rose(q.busy) || q.prog_data == ($past(nv_word) & ~tsc_pkg::LOCK_MASK))
		else $error("locked word changed beyond the lock bit");
	reserved_zero_a: assert property (
		(nv_word & ~tsc_pkg::NV_WMASK) == 16'h0000)
		else $error("reserved stored bits not zero");
	load_mode_a: assert property (
		q.mode == tsc_pkg::ST_LOAD
		|=> q.mode == ($past(nv_word[tsc_pkg::CFG_LSB]) ? tsc_pkg::ST_SHDN : tsc_pkg::ST_RUN))
		else $error("reset did not start in the stored run state");
	lock_cfg_a: assert property (
		wr_go && q.aw_addr == tsc_pkg::OFS_OPCFG && locked |=> $stable(q.cfg))
		else $error("locked operating configuration changed");
	nv_read_a: assert property (
		ar_take && ARADDR == tsc_pkg::OFS_NVCFG && !q.busy
		|=> RDATA == {16'h0000, $past(nv_word)})
		else $error("stored word not returned on read");

	alarm_rise_c: cover property ($rose(q.alarm));
	shutdown_c:   cover property (q.mode == tsc_pkg::ST_RUN ##1 q.mode == tsc_pkg::ST_SHDN);
	program_c:    cover property (nv_we);
	lock_clear_c: cover property ($fell(nv_word[tsc_pkg::BIT_LOCK]));
	alarm_clear_c: cover property (q.cfg.thermostat_mode_sel && $fell(q.alarm));
endmodule : tsc_config_regs

`default_nettype wire

// File: dv/tsc_conv_src.sv
`timescale 1ns/1ps
`default_nettype none

// far side of the conversion link: each rise of conv_clk ends one conversion
module tsc_conv_src (
	output var logic conv_clk,
	output var logic temp_over
);
	initial begin
		conv_clk  = 1'b0;
		temp_over = 1'b0;
	end

	// 80 ns link period; the link clock stands still low between bursts
	task automatic burst(input int n, input logic over);
		// step off the clock edge so the synchroniser never races a change
		#2 temp_over = over;
		repeat (n) begin
			#40 conv_clk = 1'b1;
			#40 conv_clk = 1'b0;
		end
	endtask : burst

endmodule : tsc_conv_src
`default_nettype wire

// File: dv/temp_sensor_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module temp_sensor_config_regs_tb;
	logic                       CLK, RESETN, NV_RESETN, AWVALID, AWREADY, WVALID, WREADY;
	logic                       BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
	logic                       CONV_CLK, TEMP_OVER, CONV_RUN, CONV_STORE, ALERT;
	logic [tsc_pkg::ADDR_W-1:0] AWADDR, ARADDR;
	logic [31:0]                WDATA, RDATA, rv;
	logic [3:0]                 WSTRB;
	logic [1:0]                 BRESP, RRESP, RESOLUTION, rr, br;
	int                         failures, total_checks, stores, s0;
	int                         need [4] = '{1, 2, 4, 6};

	// short programming time keeps the busy window a few bus accesses long
	tsc_config_regs #(.PROG_CYCLES(20)) dut_u (
		.CLK, .RESETN, .NV_RESETN, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY,
		.WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR,
		.RVALID, .RREADY, .RDATA, .RRESP, .CONV_CLK, .TEMP_OVER, .CONV_RUN,
		.CONV_STORE, .RESOLUTION, .ALERT
	);

	tsc_conv_src conv_u (.conv_clk(CONV_CLK), .temp_over(TEMP_OVER));

	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	always @(posedge CLK) begin
		if (CONV_STORE === 1'b1) stores <= stores + 1;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// handshakes are judged at the falling edge, where everything has settled
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic aw_hit, w_hit, b_hit;
		int   n;
		b_hit = 1'b0;
		n = 0;
		@(posedge CLK);
		AWADDR  <= a;
		WDATA   <= {16'h0000, d};
		WSTRB   <= 4'hF;
		AWVALID <= 1'b1;
		WVALID  <= 1'b1;
		BREADY  <= 1'b1;
		while (!b_hit && n < 100) begin
			@(negedge CLK);
			aw_hit = AWVALID & AWREADY;
			w_hit  = WVALID & WREADY;
			b_hit  = BVALID & BREADY;
			br     = BRESP;
			@(posedge CLK);
			if (aw_hit) AWVALID <= 1'b0;
			if (w_hit) WVALID <= 1'b0;
			n++;
		end
		if (!b_hit) begin
			failures++;
			$display("BAD bvalid expected 1 seen 0");
		end
		BREADY <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a);
		logic ar_hit, r_hit;
		int   n;
		r_hit = 1'b0;
		n = 0;
		@(posedge CLK);
		ARADDR  <= a;
		ARVALID <= 1'b1;
		RREADY  <= 1'b1;
		while (!r_hit && n < 100) begin
			@(negedge CLK);
			ar_hit = ARVALID & ARREADY;
			r_hit  = RVALID & RREADY;
			rv     = RDATA;
			rr     = RRESP;
			@(posedge CLK);
			if (ar_hit) ARVALID <= 1'b0;
			n++;
		end
		if (!r_hit) begin
			failures++;
			$display("BAD rvalid expected 1 seen 0");
		end
		RREADY <= 1'b0;
	endtask : rd

	task automatic wait_idle();
		int n;
		n = 0;
		rd(tsc_pkg::OFS_OPCFG);
		while (rv[0] !== 1'b0 && n < 50) begin
			rd(tsc_pkg::OFS_OPCFG);
			n++;
		end
		chk("idle", 32'(rv[0]), 32'h0);
	endtask : wait_idle

	// the extra cycles cover the two-stage synchroniser and the edge finder
	task automatic conv(input int n, input logic over);
		conv_u.burst(n, over);
		repeat (6) @(posedge CLK);
		@(negedge CLK);
	endtask : conv

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	initial begin
		#200000;
		failures++;
		final_report();
	end

	initial begin
		failures = 0;
		total_checks = 0;
		stores = 0;
		RESETN = 1'b0;
		NV_RESETN = 1'b0;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
		AWADDR = 5'h00;
		ARADDR = 5'h00;
		WDATA = 32'h0000_0000;
		WSTRB = 4'h0;
		repeat (6) @(posedge CLK);
		RESETN <= 1'b1;
		NV_RESETN <= 1'b1;
		rd(tsc_pkg::OFS_OPCFG);
		chk("opcfg", rv, 32'h0000_0000);
		rd(tsc_pkg::OFS_NVCFG);
		chk("nvcfg", rv, 32'h0000_0000);
		rd(5'h10);
		chk("rresp", 32'(rr), 32'(tsc_pkg::RESP_SLVERR));
		wr(5'h10, 16'h0000);
		chk("bresp", 32'(br), 32'(tsc_pkg::RESP_SLVERR));
		chk("alert idle", 32'(ALERT), 32'h1);
		$display("reset test done");
		for (int c = 0; c < 4; c++) begin
			wr(tsc_pkg::OFS_OPCFG, 16'(c << 11));
			conv(need[c] - 1, 1'b1);
			chk("alert early", 32'(ALERT), 32'h1);
			conv(1, 1'b1);
			chk("alert due", 32'(ALERT), 32'h0);
			conv(1, 1'b0);
		end
		wr(tsc_pkg::OFS_OPCFG, 16'h0400);
		@(negedge CLK);
		chk("alert high pol", 32'(ALERT), 32'h0);
		wr(tsc_pkg::OFS_OPCFG, 16'h0200);
		conv(1, 1'b1);
		conv(1, 1'b0);
		chk("alert held", 32'(ALERT), 32'h0);
		rd(tsc_pkg::OFS_STAT);
		@(negedge CLK);
		chk("alert cleared", 32'(ALERT), 32'h1);
		$display("alarm test done");
		wr(tsc_pkg::OFS_OPCFG, 16'h0100);
		rd(tsc_pkg::OFS_STAT);
		chk("still run", 32'(rv[5:4]), 32'h1);
		s0 = stores;
		conv(1, 1'b0);
		chk("last store", 32'(stores - s0), 32'h1);
		chk("run off", 32'(CONV_RUN), 32'h0);
		conv(2, 1'b0);
		chk("no store", 32'(stores - s0), 32'h1);
		wr(tsc_pkg::OFS_OPCFG, 16'h1000);
		conv(2, 1'b0);
		chk("resumed", 32'(stores - s0), 32'h3);
		$display("shutdown test done");
		wr(tsc_pkg::OFS_CMD, 16'h0001);
		wait_idle();
		rd(tsc_pkg::OFS_NVCFG);
		chk("copy to nv", rv, 32'h0000_1000);
		wr(tsc_pkg::OFS_OPCFG, 16'h0000);
		wr(tsc_pkg::OFS_CMD, 16'h0002);
		rd(tsc_pkg::OFS_OPCFG);
		chk("copy from nv", rv, 32'h0000_1000);
		// config differs from the stored byte so a wrongly honoured copy shows
		wr(tsc_pkg::OFS_OPCFG, 16'h0000);
		wr(tsc_pkg::OFS_NVCFG, 16'hEFFB);
		rd(tsc_pkg::OFS_OPCFG);
		chk("busy", rv, 32'h0000_0001);
		wr(tsc_pkg::OFS_NVCFG, 16'h0000);
		chk("bresp dropped", 32'(br), 32'(tsc_pkg::RESP_OKAY));
		wr(tsc_pkg::OFS_CMD, 16'h0002);
		rd(tsc_pkg::OFS_OPCFG);
		chk("copy dropped", rv, 32'h0000_0001);
		wait_idle();
		rd(tsc_pkg::OFS_NVCFG);
		chk("stored", rv, 32'h0000_6F02);
		@(posedge CLK);
		RESETN <= 1'b0;
		repeat (6) @(posedge CLK);
		RESETN <= 1'b1;
		rd(tsc_pkg::OFS_OPCFG);
		chk("reload", rv, 32'h0000_6F00);
		chk("resolution", 32'(RESOLUTION), 32'h3);
		chk("start shut", 32'(CONV_RUN), 32'h0);
		chk("alert pol", 32'(ALERT), 32'h0);
		rd(tsc_pkg::OFS_NVCFG);
		chk("retained", rv, 32'h0000_6F02);
		$display("nonvolatile test done");
		wr(tsc_pkg::OFS_OPCFG, 16'h0000);
		rd(tsc_pkg::OFS_OPCFG);
		chk("locked cfg", rv, 32'h0000_6F00);
		wr(tsc_pkg::OFS_NVCFG, 16'h0000);
		wait_idle();
		rd(tsc_pkg::OFS_NVCFG);
		chk("unlock only", rv, 32'h0000_6F00);
		wr(tsc_pkg::OFS_NVCFG, 16'h0004);
		wait_idle();
		wr(tsc_pkg::OFS_NVCFG, 16'h0000);
		wait_idle();
		rd(tsc_pkg::OFS_NVCFG);
		chk("lockdown nv", rv, 32'h0000_0004);
		wr(tsc_pkg::OFS_OPCFG, 16'h0400);
		rd(tsc_pkg::OFS_OPCFG);
		chk("lockdown cfg", rv, 32'h0000_6F00);
		$display("lock test done");
		final_report();
	end

endmodule : temp_sensor_config_regs_tb
`default_nettype wire
